// File: design/wdtmf_top.sv
// watchdog mode/flag control register with counter, APB slave and interrupts
//
// Summary of operation
// - counter wrap FF to 00 sets flag
// - watchdog internal reset clears wrap flag
// - clear flag only after read-while-set then zero
// - mode bit writes need guard bit 6 zero
// - mode bit 5 resets 0, 0 watchdog
// - irq enable writes need guard bit 4 zero
// - irq enable bit 3 resets 0, gates itv_irq only (irq is gated by the event mask)
// - watchdog mode wrap makes internal reset
// - interval mode wrap raises interval event
// - counter is 8-bit up-counter
`timescale 1ns/1ps
module wdtmf_top
   import wdtmf_pkg::*;
#(
   parameter int PRESC     = WDTMF_PRESC_DEF,
   parameter int RST_CYC   = WDTMF_RSTPULSE_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // watchdog outputs
   output logic             wdt_reset_req,
   output logic             itv_irq,
   output logic             irq
);
   initial begin
      if (RST_CYC < 1) $error("wdtmf_top: RST_CYC must be at least 1");
      if (RST_CYC > 255) $error("wdtmf_top: RST_CYC must fit 8 bits");
   end

   // ------------------------------------------------------------
   // address match, shared by every register select
   // ------------------------------------------------------------
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
      return addr == ofs;
   endfunction : reg_hit

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   wire acc      = psel && penable;
   wire wr_acc   = acc && pwrite;
   wire rd_acc   = acc && !pwrite;
   wire hit_ctrl = reg_hit(paddr, WDTMF_CTRL_OFS);
   wire hit_cnt  = reg_hit(paddr, WDTMF_COUNT_OFS);
   wire hit_cfg  = reg_hit(paddr, WDTMF_CFG_OFS);
   wire hit_stat = reg_hit(paddr, WDTMF_STAT_OFS);
   wire hit_mask = reg_hit(paddr, WDTMF_MASK_OFS);
   wire mapped   = hit_ctrl | hit_cnt | hit_cfg | hit_stat | hit_mask;
   // only byte lane 0 carries the 8-bit control value; partial-lane writes of others are ignored
   wire lane0    = pstrb[0];
   wire wr_ctrl  = wr_acc && hit_ctrl && lane0;
   wire wr_cfg   = wr_acc && hit_cfg && lane0;
   wire wr_stat  = wr_acc && hit_stat && lane0;
   wire wr_mask  = wr_acc && hit_mask && lane0;
   wire rd_ctrl  = rd_acc && hit_ctrl;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic       wrap_flag_ff;
   logic       rd_armed_ff;
   logic       mode_ff;
   logic       ien_ff;
   logic       run_ff;
   logic       rsel_ff;
   logic [2:0] ev_ff;
   logic [2:0] mask_ff;
   logic [7:0] rst_cnt_ff;
   logic       itv_ff;
   logic [7:0] count;
   logic       wrap;

   wdtmf_counter #(
      .PRESC (PRESC)
   ) u_counter (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run_ff),
      .clear   (wdt_reset_req),
      .count   (count),
      .wrap    (wrap)
   );

   // ------------------------------------------------------------
   // control register next values
   // ------------------------------------------------------------
   wire wd_mode   = (mode_ff == 1'b0);
   wire rst_fire  = wrap && wd_mode && rsel_ff;
   wire in_rst    = (rst_cnt_ff != 8'h00);
   wire rst_end   = (rst_cnt_ff == 8'h01);
   wire zero_wr   = wr_ctrl && !pwdata[WDTMF_WRAP_BIT];
   wire flag_clr  = zero_wr && rd_armed_ff;
   // set wins over clear; reset end clears flag
   wire nxt_wrap_flag = wrap ? 1'b1 : ((flag_clr || rst_end) ? 1'b0 : wrap_flag_ff);
   wire nxt_rd_armed  = rd_ctrl ? wrap_flag_ff : (wr_ctrl ? 1'b0 : rd_armed_ff);
   wire mode_wr   = wr_ctrl && !pwdata[WDTMF_MGRD_BIT];
   wire ien_wr    = wr_ctrl && !pwdata[WDTMF_IGRD_BIT];
   wire nxt_mode  = mode_wr ? pwdata[WDTMF_MODE_BIT] : mode_ff;
   wire nxt_ien   = ien_wr ? pwdata[WDTMF_IEN_BIT] : ien_ff;
   wire itv_ev    = wrap && !wd_mode;
   wire [7:0] nxt_rst_cnt = rst_fire ? 8'(RST_CYC) : (in_rst ? rst_cnt_ff - 8'h01 : rst_cnt_ff);

   // ------------------------------------------------------------
   // interrupt status: sticky, write one to clear, set wins
   // ------------------------------------------------------------
   wire [2:0] ev_in  = {itv_ev, rst_fire, wrap};
   wire [2:0] ev_clr = wr_stat ? pwdata[2:0] : 3'h0;
   wire [2:0] nxt_ev = ev_in | (ev_ff & ~ev_clr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_flag_ff <= 1'b0;
         rd_armed_ff  <= 1'b0;
         mode_ff      <= WDTMF_MODE_RST;
         ien_ff       <= WDTMF_IEN_RST;
         rst_cnt_ff   <= 8'h00;
         itv_ff       <= 1'b0;
      end else begin
         wrap_flag_ff <= nxt_wrap_flag;
         rd_armed_ff  <= nxt_rd_armed;
         mode_ff      <= nxt_mode;
         ien_ff       <= nxt_ien;
         rst_cnt_ff   <= nxt_rst_cnt;
         itv_ff       <= itv_ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff  <= WDTMF_RUN_RST;
         rsel_ff <= WDTMF_RSEL_RST;
         ev_ff   <= WDTMF_EV_RST_V;
         mask_ff <= WDTMF_MASK_RST;
      end else begin
         run_ff  <= wr_cfg ? pwdata[WDTMF_RUN_BIT] : run_ff;
         rsel_ff <= wr_cfg ? pwdata[WDTMF_RSEL_BIT] : rsel_ff;
         ev_ff   <= nxt_ev;
         mask_ff <= wr_mask ? pwdata[2:0] : mask_ff;
      end
   end

   // ------------------------------------------------------------
   // read mux and outputs
   // ------------------------------------------------------------
   // guard bits always read back as one
   wire [7:0] ctrl_rd = {wrap_flag_ff, 1'b1, mode_ff, 1'b1, ien_ff, 3'b000};
   wire [31:0] rd_mux =
      hit_ctrl ? {24'h00_0000, ctrl_rd} :
      hit_cnt  ? {24'h00_0000, count} :
      hit_cfg  ? {30'h0000_0000, rsel_ff, run_ff} :
      hit_stat ? {29'h0000_0000, ev_ff} :
      hit_mask ? {29'h0000_0000, mask_ff} : 32'h0000_0000;

   assign prdata        = rd_mux;
   assign pready        = 1'b1;
   assign pslverr       = acc && !mapped;
   assign wdt_reset_req = in_rst;
   assign itv_irq       = wrap_flag_ff && !wd_mode && ien_ff;
   assign irq           = |(ev_ff & mask_ff);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   wrap_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap |=> wrap_flag_ff) else $error("wrap did not set flag");
   blind_zero_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
      (zero_wr && !rd_armed_ff && wrap_flag_ff && !rst_end) |=> wrap_flag_ff)
      else $error("flag cleared without prior read");
   guarded_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ctrl && pwdata[WDTMF_MGRD_BIT]) |=> $stable(mode_ff)) else $error("mode changed despite guard");
   guarded_ien_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ctrl && pwdata[WDTMF_IGRD_BIT]) |=> $stable(ien_ff)) else $error("enable changed despite guard");
   wd_reset_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      rst_fire |=> wdt_reset_req) else $error("no internal reset after wrap");
   reset_clears_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rst_end && !wrap) |=> !wrap_flag_ff) else $error("internal reset left flag set");
   itv_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wrap && mode_ff) |=> itv_ff && ev_ff[WDTMF_EV_ITV]) else $error("interval event missing");
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      itv_irq == (wrap_flag_ff && mode_ff && ien_ff)) else $error("interval irq level wrong");
   ien_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ien_ff |-> !itv_irq) else $error("irq not suppressed");
   counter_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap |-> (count == 8'h00)) else $error("wrap without counter at zero");


   // ------------------------------------------------------------
   // assertions: register bus
   // ------------------------------------------------------------
   // an unmapped access must answer with an error and zero data, never a silent hit
   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && !mapped) |-> (pslverr && prdata == 32'h0000_0000))
      else $error("unmapped access not refused");

   mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && mapped) |-> !pslverr)
      else $error("mapped access flagged as error");

   unmapped_nowrite_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && !mapped) |=> ($stable(mode_ff) && $stable(ien_ff) && $stable(mask_ff) && $stable(run_ff)))
      else $error("unmapped write changed a register");

   // a write without lane 0 carries no control byte, so mode and enable may not move
   lane_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_ctrl && !pstrb[0]) |=> ($stable(mode_ff) && $stable(ien_ff)))
      else $error("control changed without lane 0");

   guard_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_ctrl |-> (prdata[WDTMF_MGRD_BIT] && prdata[WDTMF_IGRD_BIT] && prdata[2:0] == 3'b000))
      else $error("guard or reserved bits read wrong");

   // ------------------------------------------------------------
   // assertions: flag clear sequence and guarded fields
   // ------------------------------------------------------------
   read_arms_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_ctrl && wrap_flag_ff) |=> rd_armed_ff)
      else $error("read of set flag did not arm clear");

   // any control write spends the arming, so a stale read cannot clear a later flag
   write_disarms_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> !rd_armed_ff)
      else $error("clear arming survived a write");

   armed_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (flag_clr && !wrap) |=> !wrap_flag_ff)
      else $error("armed zero write left flag set");

   flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!wrap && !flag_clr && !rst_end) |=> (wrap_flag_ff == $past(wrap_flag_ff)))
      else $error("flag moved without cause");

   mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_wr |=> (mode_ff == $past(pwdata[WDTMF_MODE_BIT])))
      else $error("unguarded mode write lost");

   ien_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      ien_wr |=> (ien_ff == $past(pwdata[WDTMF_IEN_BIT])))
      else $error("unguarded enable write lost");

   // ------------------------------------------------------------
   // assertions: internal reset and status
   // ------------------------------------------------------------
   rst_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (in_rst && !rst_fire) |=> (rst_cnt_ff == $past(rst_cnt_ff) - 8'h01))
      else $error("reset pulse length counter skipped");

   // the counter is held during the pulse so no second wrap can stack on the first
   rst_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_reset_req |=> (count == 8'h00))
      else $error("counter ran during internal reset");

   itv_no_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wrap && mode_ff) |=> !wdt_reset_req)
      else $error("interval wrap raised internal reset");

   status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((ev_ff & $past(ev_in)) == $past(ev_in)))
      else $error("status event lost");

   status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (((ev_ff | $past(ev_clr)) & $past(ev_ff)) == $past(ev_ff)))
      else $error("status bit dropped without clear");

   wrap_seen_c: cover property (@(posedge pclk) disable iff (!presetn) wrap);
   guard_block_c: cover property (@(posedge pclk) disable iff (!presetn)
      wr_ctrl && pwdata[WDTMF_MGRD_BIT] && (pwdata[WDTMF_MODE_BIT] != mode_ff));
   flag_cleared_c: cover property (@(posedge pclk) disable iff (!presetn) flag_clr && wrap_flag_ff);
   itv_irq_c: cover property (@(posedge pclk) disable iff (!presetn) itv_irq);
   wd_reset_c: cover property (@(posedge pclk) disable iff (!presetn) rst_fire);
endmodule : wdtmf_top

// File: design/wdtmf_pkg.sv
// package: register map, field positions, reset values and timing for the watchdog mode/flag control block
package wdtmf_pkg;
   // register byte addresses
   localparam logic [11:0] WDTMF_CTRL_OFS   = 12'h000;   // watchdog_control_status_two
   localparam logic [11:0] WDTMF_COUNT_OFS  = 12'h004;   // watchdog_counter (read only, writes are ignored)
   localparam logic [11:0] WDTMF_CFG_OFS    = 12'h008;   // run enable, reset select
   localparam logic [11:0] WDTMF_STAT_OFS   = 12'h00C;   // sticky event status, write one to clear
   localparam logic [11:0] WDTMF_MASK_OFS   = 12'h010;   // event mask
   // control register field positions
   localparam int WDTMF_WRAP_BIT  = 7;
   localparam int WDTMF_MGRD_BIT  = 6;
   localparam int WDTMF_MODE_BIT  = 5;
   localparam int WDTMF_IGRD_BIT  = 4;
   localparam int WDTMF_IEN_BIT   = 3;
   // config register field positions
   localparam int WDTMF_RUN_BIT   = 0;
   localparam int WDTMF_RSEL_BIT  = 1;
   // status / mask positions
   localparam int WDTMF_EV_WRAP   = 0;
   localparam int WDTMF_EV_RST    = 1;
   localparam int WDTMF_EV_ITV    = 2;
   // reset values
   localparam logic        WDTMF_MODE_RST  = 1'b0;
   localparam logic        WDTMF_IEN_RST   = 1'b0;
   localparam logic        WDTMF_RUN_RST   = 1'b1;
   localparam logic        WDTMF_RSEL_RST  = 1'b1;
   localparam logic [7:0]  WDTMF_CNT_RST   = 8'h00;
   localparam logic [7:0]  WDTMF_CNT_MAX   = 8'hFF;
   localparam logic [2:0]  WDTMF_EV_RST_V  = 3'h0;
   localparam logic [2:0]  WDTMF_MASK_RST  = 3'h0;
   // timing: internal reset pulse length
   localparam int WDTMF_CLK_MHZ      = 100;
   localparam int WDTMF_RSTPULSE_NS  = 80;
   localparam int WDTMF_RSTPULSE_CYC = (WDTMF_RSTPULSE_NS * WDTMF_CLK_MHZ + 999) / 1000;
   localparam int WDTMF_PRESC_DEF    = 16;
endpackage : wdtmf_pkg

// File: design/wdtmf_counter.sv
// 8-bit watchdog up-counter with prescaler and wrap pulse
`timescale 1ns/1ps
module wdtmf_counter
   import wdtmf_pkg::*;
#(
   parameter int PRESC = WDTMF_PRESC_DEF
) (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic       run,
   input  wire logic       clear,
   // state
   output logic [7:0]      count,
   output logic            wrap
);
   localparam int PW = (PRESC > 1) ? $clog2(PRESC) : 1;

   initial begin
      if (PRESC < 1) $error("wdtmf_counter: PRESC must be at least 1");
   end

   logic [PW-1:0] presc_ff;
   logic [7:0]    count_ff;
   logic          wrap_ff;
   wire           tick      = run && (presc_ff == PW'(PRESC - 1));
   wire [PW-1:0]  nxt_presc = (!run || tick) ? '0 : presc_ff + PW'(1);
   wire [7:0]     nxt_count = clear ? WDTMF_CNT_RST : (tick ? count_ff + 8'h01 : count_ff);
   wire           nxt_wrap  = !clear && tick && (count_ff == WDTMF_CNT_MAX);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_ff <= '0;
         count_ff <= WDTMF_CNT_RST;
         wrap_ff  <= 1'b0;
      end else begin
         presc_ff <= nxt_presc;
         count_ff <= nxt_count;
         wrap_ff  <= nxt_wrap;
      end
   end

   assign count = count_ff;
   assign wrap  = wrap_ff;
endmodule : wdtmf_counter

// File: tb/wdt_mode_flag_control_test.sv
// self-checking testbench for the watchdog mode/flag control block
`timescale 1ns/1ps
module wdt_mode_flag_control_test
   import wdtmf_pkg::*;
;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wdt_reset_req;
   logic        itv_irq;
   logic        irq;
   logic [31:0] rv;
   logic        ev;
   int          n_fail = 0;
   int          checks_done = 0;

   always #5 pclk = ~pclk;

   // prescale of one keeps a wrap at 256 cycles
   wdtmf_top #(.PRESC(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wdt_reset_req(wdt_reset_req), .itv_irq(itv_irq), .irq(irq));

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic report_and_stop;
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         n_fail++;
      end
   endtask : chk

   // read data and error are taken at the rising edge that samples pready high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         report_and_stop();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv, ev);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, rv, ev);
      chk(rv, e);
   endtask : rd_chk

   function automatic logic pick(input int s);
      return (s == 0) ? wdt_reset_req : itv_irq;
   endfunction : pick

   task automatic wait_lvl(input int s, input logic lvl);
      int n;
      n = 0;
      while (pick(s) !== lvl && n < 600) begin
         @(negedge pclk);
         n++;
      end
      if (pick(s) !== lvl) begin
         n_fail++;
         report_and_stop();
      end
   endtask : wait_lvl

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic reset_values;
      rd_chk(WDTMF_CTRL_OFS, 32'h0000_0050);
      rd_chk(WDTMF_CFG_OFS, 32'h0000_0003);
      rd_chk(WDTMF_MASK_OFS, 32'h0000_0000);
   endtask : reset_values

   task automatic guarded_writes;
      wr(WDTMF_CTRL_OFS, 32'h0000_0078);
      rd_chk(WDTMF_CTRL_OFS, 32'h0000_0050);
      wr(WDTMF_CTRL_OFS, 32'h0000_0028);
      rd_chk(WDTMF_CTRL_OFS, 32'h0000_0078);
      wr(WDTMF_CTRL_OFS, 32'h0000_0000);
      rd_chk(WDTMF_CTRL_OFS, 32'h0000_0050);
   endtask : guarded_writes

   task automatic watchdog_wrap;
      wait_lvl(0, 1'b1);
      rd_chk(WDTMF_CTRL_OFS, 32'h0000_00D0);
      wait_lvl(0, 1'b0);
      rd_chk(WDTMF_CTRL_OFS, 32'h0000_0050);
      rd_chk(WDTMF_STAT_OFS, 32'h0000_0003);
   endtask : watchdog_wrap

   task automatic interval_flag_clear;
      wr(WDTMF_CTRL_OFS, 32'h0000_0028);
      wr(WDTMF_STAT_OFS, 32'h0000_0007);
      wr(WDTMF_MASK_OFS, 32'h0000_0004);
      chk({31'd0, irq}, 32'h0000_0000);
      wait_lvl(1, 1'b1);
      chk({30'd0, irq, wdt_reset_req}, 32'h0000_0002);
      wr(WDTMF_CTRL_OFS, 32'h0000_0028);
      rd_chk(WDTMF_CTRL_OFS, 32'h0000_00F8);
      wr(WDTMF_CTRL_OFS, 32'h0000_0028);
      rd_chk(WDTMF_CTRL_OFS, 32'h0000_0078);
      chk({31'd0, itv_irq}, 32'h0000_0000);
   endtask : interval_flag_clear

   task automatic masked_and_disabled;
      int n;
      wr(WDTMF_CTRL_OFS, 32'h0000_0020);
      wr(WDTMF_STAT_OFS, 32'h0000_0007);
      wr(WDTMF_MASK_OFS, 32'h0000_0000);
      n = 0;
      do begin
         apb(1'b0, WDTMF_CTRL_OFS, 32'h0000_0000, rv, ev);
         n++;
      end while (rv[WDTMF_WRAP_BIT] !== 1'b1 && n < 200);
      chk(rv, 32'h0000_00F0);
      chk({30'd0, itv_irq, irq}, 32'h0000_0000);
      rd_chk(WDTMF_STAT_OFS, 32'h0000_0005);
      apb(1'b0, 12'h100, 32'h0000_0000, rv, ev);
      chk({rv[30:0], ev}, 32'h0000_0001);
   endtask : masked_and_disabled

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      guarded_writes();
      watchdog_wrap();
      interval_flag_clear();
      masked_and_disabled();
      report_and_stop();
   end
endmodule : wdt_mode_flag_control_test
